// File: verilog/rsama_pkg.sv
// Constants, types and the behaviour summary of the modular arithmetic unit
// What this block does
// - Entry 0x00A computes A*B*R^-1 mod N, R = 2^(16*digits).
// - After a multiply, A is kept and the product replaces B in place.
// - Entry 0x00B computes A*B*R^-2 mod N, one more R divided out.
// - Multiply accepts operands that are not in Montgomery form.
// - Entry 0x008 computes (A+B) mod N for operands below N.
// - Modular add writes its sum into the selected B sub-register.
// - Modular add treats Montgomery and plain operands the same.
// - The unit honours the programmed A, B and N operand pointers.
package rsama_pkg;
	localparam int DIGIT_W = 16;
	localparam int SUB_DIGITS = 32;
	localparam int SUB_COUNT = 4;
	localparam int ADDR_W = 7;
	localparam int IDX_W = 8;
	localparam int SIZE_W = 7;
	localparam int INV_STEPS = 4;
	localparam logic [3:0] ENTRY_ADD = 4'h8;
	localparam logic [3:0] ENTRY_MUL = 4'hA;
	localparam logic [3:0] ENTRY_MUL2 = 4'hB;
	localparam logic [1:0] SEL_A = 2'h0;
	localparam logic [1:0] SEL_B = 2'h1;
	localparam logic [1:0] SEL_N = 2'h2;
	localparam logic [DIGIT_W-1:0] DIGIT_ONE = 16'h0001;
	localparam logic [DIGIT_W-1:0] INV_TWO = 16'h0002;

	typedef enum logic [3:0] {
		RSAMA_IDLE, RSAMA_CLR, RSAMA_INV, RSAMA_MULA, RSAMA_MRED,
		RSAMA_ADDP, RSAMA_SUBP, RSAMA_COPY, RSAMA_FIN
	} rsama_state_t;

	// Host access to the operand memories
	typedef struct packed {
		logic we;
		logic [1:0] sel;
		logic [ADDR_W-1:0] addr;
		logic [DIGIT_W-1:0] data;
	} rsama_mem_t;

	// Routine request and its settings
	typedef struct packed {
		logic start;
		logic [3:0] entry;
		logic [1:0] aOperandPointer;
		logic [1:0] bOperandPointer;
		logic [1:0] nOperandPointer;
		logic [SIZE_W-1:0] modSize;
		logic eccSelect;
		logic binaryFieldSelect;
	} rsama_cmd_t;

	typedef struct packed {
		rsama_state_t st;
		logic [3:0] op;
		logic pass2;
		logic [1:0] aPtr;
		logic [1:0] bPtr;
		logic [1:0] nPtr;
		logic [IDX_W-1:0] digits;
		logic [IDX_W-1:0] i;
		logic [IDX_W-1:0] j;
		logic [DIGIT_W-1:0] carry;
		logic [DIGIT_W-1:0] m;
		logic [DIGIT_W-1:0] inv;
		logic [1:0] k;
		logic busy;
		logic done;
		logic cmdError;
		logic [DIGIT_W-1:0] rdData;
	} rsama_regs_t;
endpackage

// File: verilog/rsama_mac.sv
// One digit multiply-accumulate: t + a*b + c, never overflows 32 bits
`timescale 1ns/10ps
module rsama_mac import rsama_pkg::*; (
	input wire logic [DIGIT_W-1:0] t,
	input wire logic [DIGIT_W-1:0] a,
	input wire logic [DIGIT_W-1:0] b,
	input wire logic [DIGIT_W-1:0] c,
	output logic [2*DIGIT_W-1:0] sum
);
	// (2^16-1)^2 + 2*(2^16-1) = 2^32-1, so the result always fits
	always_comb begin
		sum = (2*DIGIT_W)'(a) * (2*DIGIT_W)'(b) + (2*DIGIT_W)'(t)
			+ (2*DIGIT_W)'(c);
	end
endmodule

// File: verilog/rsama_unit.sv
// Digit-serial Montgomery multiply and modular add engine
`timescale 1ns/10ps
module rsama_unit import rsama_pkg::*; #(
	parameter int SUBD = SUB_DIGITS
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire rsama_mem_t hostMem,
	input wire rsama_cmd_t cmd,
	output logic [DIGIT_W-1:0] memRdData,
	output logic busy,
	output logic done,
	output logic cmdError
);
	localparam int DEPTH = SUB_COUNT * SUBD;
	localparam int TDEPTH = DEPTH + 2;

	// Refused at elaboration: addressing assumes power-of-two sub-registers
	if (SUBD > SUB_DIGITS || SUBD < 2 || (SUBD & (SUBD - 1)) != 0) begin
		$error("SUBD must be a power of two from 2 to SUB_DIGITS");
	end

	rsama_regs_t s_q;
	rsama_regs_t s_d;
	logic [DIGIT_W-1:0] aMem [DEPTH];
	logic [DIGIT_W-1:0] bMem [DEPTH];
	logic [DIGIT_W-1:0] nMem [DEPTH];
	logic [DIGIT_W-1:0] tMem [TDEPTH];
	logic tWe;
	logic [IDX_W-1:0] tAddr;
	logic [DIGIT_W-1:0] tData;
	logic bWe;
	logic [ADDR_W-1:0] bAddr;
	logic [DIGIT_W-1:0] bData;
	logic [DIGIT_W-1:0] macT;
	logic [DIGIT_W-1:0] macA;
	logic [DIGIT_W-1:0] macB;
	logic [DIGIT_W-1:0] macC;
	logic [2*DIGIT_W-1:0] macSum;
	logic [DIGIT_W-1:0] aDig;
	logic [DIGIT_W-1:0] bDig;
	logic [DIGIT_W-1:0] nDig;
	logic [DIGIT_W-1:0] tDig;
	logic [2*DIGIT_W-1:0] mProd;
	logic [DIGIT_W:0] diff;
	logic inRange;
	logic legal;

	// Operand digit address: sub-register picked by pointer, wraps in memory
	function automatic logic [ADDR_W-1:0] digitAddr(input logic [1:0] ptr,
		input logic [IDX_W-1:0] idx);
		int s;
		s = int'(ptr) * SUBD + int'(idx);
		return ADDR_W'(s % DEPTH);
	endfunction

	rsama_mac u_mac (
		.t(macT),
		.a(macA),
		.b(macB),
		.c(macC),
		.sum(macSum)
	);

	// Operand fetch follows the latched pointers
	always_comb begin
		inRange = s_q.j < s_q.digits;
		tDig = tMem[s_q.j];
		nDig = inRange ? nMem[digitAddr(s_q.nPtr, s_q.j)] : '0;
		bDig = bMem[digitAddr(s_q.bPtr, (s_q.st == RSAMA_MULA) ? s_q.i : s_q.j)];
		// Second pass multiplies the first result by one: one more R out
		if (s_q.pass2)
			aDig = (s_q.j == '0) ? DIGIT_ONE : '0;
		else
			aDig = aMem[digitAddr(s_q.aPtr, s_q.j)];
		mProd = (2*DIGIT_W)'(tMem[0]) * (2*DIGIT_W)'(s_q.inv);
		diff = {1'b0, tDig} - {1'b0, nDig} - (DIGIT_W+1)'(s_q.carry[0]);
		legal = (cmd.entry == ENTRY_ADD || cmd.entry == ENTRY_MUL
			|| cmd.entry == ENTRY_MUL2) && !cmd.eccSelect
			&& !cmd.binaryFieldSelect;
	end

	// Sequencer: one digit operation per cycle
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.cmdError = 1'b0;
		tWe = 1'b0;
		tAddr = s_q.j;
		tData = macSum[DIGIT_W-1:0];
		bWe = 1'b0;
		bAddr = digitAddr(s_q.bPtr, s_q.j);
		bData = diff[DIGIT_W-1:0];
		macT = tDig;
		macA = '0;
		macB = '0;
		macC = s_q.carry;
		case (hostMem.sel)
			SEL_A: s_d.rdData = aMem[hostMem.addr];
			SEL_B: s_d.rdData = bMem[hostMem.addr];
			default: s_d.rdData = nMem[hostMem.addr];
		endcase
		case (s_q.st)
			RSAMA_IDLE: begin
				if (cmd.start && legal) begin
					s_d.op = cmd.entry;
					s_d.aPtr = cmd.aOperandPointer;
					s_d.bPtr = cmd.bOperandPointer;
					s_d.nPtr = cmd.nOperandPointer;
					s_d.digits = IDX_W'(cmd.modSize) + IDX_W'(1);
					s_d.pass2 = 1'b0;
					s_d.busy = 1'b1;
					s_d.i = '0;
					s_d.j = '0;
					s_d.carry = '0;
					s_d.st = (cmd.entry == ENTRY_ADD) ? RSAMA_ADDP : RSAMA_CLR;
				end else if (cmd.start) begin
					s_d.cmdError = 1'b1;
				end
			end
			// Accumulator cleared over digits+2 words
			RSAMA_CLR: begin
				tWe = 1'b1;
				tData = '0;
				s_d.j = s_q.j + IDX_W'(1);
				if (s_q.j == s_q.digits + IDX_W'(1)) begin
					s_d.j = '0;
					s_d.k = '0;
					s_d.inv = DIGIT_ONE;
					s_d.st = RSAMA_INV;
				end
			end
			// Newton steps for -1/N0 mod 2^16: 1,2,4,8,16 good bits
			RSAMA_INV: begin
				s_d.inv = DIGIT_W'(s_q.inv * DIGIT_W'(INV_TWO
					- DIGIT_W'(nMem[digitAddr(s_q.nPtr, '0)] * s_q.inv)));
				s_d.k = s_q.k + 2'h1;
				if (s_q.k == 2'(INV_STEPS - 1)) begin
					s_d.inv = '0 - DIGIT_W'(s_q.inv * DIGIT_W'(INV_TWO
						- DIGIT_W'(nMem[digitAddr(s_q.nPtr, '0)] * s_q.inv)));
					s_d.st = RSAMA_MULA;
				end
			end
			// T += A * B[i]; plain or residue operands alike
			RSAMA_MULA: begin
				macA = inRange ? aDig : '0;
				macB = inRange ? bDig : '0;
				tWe = 1'b1;
				s_d.carry = macSum[2*DIGIT_W-1:DIGIT_W];
				s_d.j = s_q.j + IDX_W'(1);
				if (s_q.j == s_q.digits + IDX_W'(1)) begin
					s_d.j = '0;
					s_d.carry = '0;
					s_d.st = RSAMA_MRED;
				end
			end
			// T = (T + m*N) / 2^16, one digit shift per outer step
			RSAMA_MRED: begin
				if (s_q.j == '0) begin
					macT = tMem[0];
					macA = mProd[DIGIT_W-1:0];
					macB = nDig;
					macC = '0;
					s_d.m = mProd[DIGIT_W-1:0];
				end else if (s_q.j <= s_q.digits + IDX_W'(1)) begin
					macA = s_q.m;
					macB = nDig;
					tWe = 1'b1;
					tAddr = s_q.j - IDX_W'(1);
				end else begin
					// Top word vacated by the shift; stale value would be added again
					tWe = 1'b1;
					tAddr = s_q.j - IDX_W'(1);
					tData = '0;
				end
				s_d.carry = macSum[2*DIGIT_W-1:DIGIT_W];
				s_d.j = s_q.j + IDX_W'(1);
				if (s_q.j == s_q.digits + IDX_W'(2)) begin
					s_d.j = '0;
					s_d.carry = '0;
					s_d.i = s_q.i + IDX_W'(1);
					s_d.st = (s_q.i == s_q.digits - IDX_W'(1)) ? RSAMA_SUBP
						: RSAMA_MULA;
				end
			end
			// T = A + B over digits+1 words
			RSAMA_ADDP: begin
				macT = inRange ? aDig : '0;
				macA = inRange ? bDig : '0;
				macB = DIGIT_ONE;
				tWe = 1'b1;
				s_d.carry = macSum[2*DIGIT_W-1:DIGIT_W];
				s_d.j = s_q.j + IDX_W'(1);
				if (s_q.j == s_q.digits) begin
					s_d.j = '0;
					s_d.carry = '0;
					s_d.st = RSAMA_SUBP;
				end
			end
			// B = T - N; kept only if no final borrow (T was below 2N)
			RSAMA_SUBP: begin
				bWe = inRange;
				s_d.carry = {{(DIGIT_W-1){1'b0}}, diff[DIGIT_W]};
				s_d.j = s_q.j + IDX_W'(1);
				if (s_q.j == s_q.digits) begin
					s_d.j = '0;
					s_d.st = diff[DIGIT_W] ? RSAMA_COPY : RSAMA_FIN;
				end
			end
			// Borrow out: T already below N, so T itself is the result
			RSAMA_COPY: begin
				bWe = 1'b1;
				bData = tDig;
				s_d.j = s_q.j + IDX_W'(1);
				if (s_q.j == s_q.digits - IDX_W'(1)) begin
					s_d.j = '0;
					s_d.st = RSAMA_FIN;
				end
			end
			RSAMA_FIN: begin
				s_d.carry = '0;
				s_d.i = '0;
				s_d.j = '0;
				if (s_q.op == ENTRY_MUL2 && !s_q.pass2) begin
					s_d.pass2 = 1'b1;
					s_d.st = RSAMA_CLR;
				end else begin
					s_d.busy = 1'b0;
					s_d.done = 1'b1;
					s_d.st = RSAMA_IDLE;
				end
			end
			default: s_d.st = RSAMA_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Memories; host writes are ignored while a routine runs
	always_ff @(posedge clk_sys) begin
		if (tWe)
			tMem[tAddr] <= tData;
		if (bWe)
			bMem[bAddr] <= bData;
		else if (hostMem.we && !s_q.busy && hostMem.sel == SEL_B)
			bMem[hostMem.addr] <= hostMem.data;
		if (hostMem.we && !s_q.busy && hostMem.sel == SEL_A)
			aMem[hostMem.addr] <= hostMem.data;
		if (hostMem.we && !s_q.busy && hostMem.sel == SEL_N)
			nMem[hostMem.addr] <= hostMem.data;
	end

	assign memRdData = s_q.rdData;
	assign busy = s_q.busy;
	assign done = s_q.done;
	assign cmdError = s_q.cmdError;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	startBusy_a: assert property (!s_q.busy && cmd.start && legal
		|=> busy) else $error("legal start did not raise busy");
	refuseCmd_a: assert property (!s_q.busy && cmd.start && !legal
		|=> !busy && cmdError) else $error("illegal start not refused");
	aKept_a: assert property (s_q.busy |-> ##1 $stable(aMem[0]))
		else $error("A operand changed during a routine");
	bLate_a: assert property (bWe |-> s_q.st == RSAMA_SUBP
		|| s_q.st == RSAMA_COPY) else $error("B written too early");
	addNoMul_a: assert property (s_q.op == ENTRY_ADD && s_q.busy
		|-> s_q.st != RSAMA_MULA && s_q.st != RSAMA_MRED)
		else $error("add entered multiply states");
	dblPass_a: assert property (s_q.st == RSAMA_FIN
		&& s_q.op == ENTRY_MUL2 && !s_q.pass2
		|=> s_q.st == RSAMA_CLR && s_q.pass2)
		else $error("double reduction skipped second pass");
	invGood_a: assert property (s_q.st == RSAMA_MRED && s_q.j == '0
		&& nMem[digitAddr(s_q.nPtr, '0)][0]
		|-> DIGIT_W'(s_q.inv * nMem[digitAddr(s_q.nPtr, '0)]) == '1)
		else $error("reduction constant wrong");
	donePulse_a: assert property (done |-> !busy ##1 !done)
		else $error("done not a single pulse");
	ptrLatch_a: assert property (s_q.busy |=> $stable(s_q.bPtr))
		else $error("pointer changed during a routine");

	mulDone_c: cover property (s_q.op == ENTRY_MUL && done);
	dblDone_c: cover property (s_q.op == ENTRY_MUL2 && done);
	addCopy_c: cover property (s_q.op == ENTRY_ADD && s_q.st == RSAMA_COPY);
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the modular arithmetic unit
`timescale 1ns/10ps
module tb_top import rsama_pkg::*;;
	logic clkSys;
	logic sysRst;
	rsama_mem_t hostMem;
	rsama_cmd_t cmd;
	logic [DIGIT_W-1:0] memRdData;
	logic busy;
	logic done;
	logic cmdError;
	logic [31:0] lfsrQ = 32'h0367;
	int errorCnt;
	int cmpCount;

	rsama_unit DUT (.clk_sys(clkSys), .sys_rst(sysRst), .hostMem(hostMem),
		.cmd(cmd), .memRdData(memRdData), .busy(busy), .done(done),
		.cmdError(cmdError));

	// Free-running system clock
	initial begin
		clkSys = 1'b0;
		forever #5 clkSys = ~clkSys;
	end

	// Random digits for operands, repeatable from a fixed start value
	function automatic logic [15:0] nextRand();
		lfsrQ = {lfsrQ[30:0], lfsrQ[31] ^ lfsrQ[21] ^ lfsrQ[1] ^ lfsrQ[0]};
		return lfsrQ[15:0];
	endfunction

	function automatic logic [255:0] randVec(input int d);
		logic [255:0] v;
		v = '0;
		for (int k = 0; k < d; k++) v[16*k+:16] = nextRand();
		return v;
	endfunction

	// Bit-serial reference for A*B*R^-1 mod N; needs an odd modulus
	function automatic logic [255:0] mont(input logic [255:0] a, b, n,
		input int d);
		logic [255:0] t;
		t = a * b;
		for (int i = 0; i < 16 * d; i++) begin
			if (t[0]) t = t + n;
			t = t >> 1;
		end
		while (t >= n) t = t - n;
		return t;
	endfunction

	task automatic finishTest;
		$display("Comparisons %0d, mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [255:0] e, g);
		cmpCount++;
		if (g !== e) begin
			errorCnt++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	// One host write; strobe drops for a cycle between writes
	task automatic wr(input logic [1:0] s, input logic [6:0] ad,
		input logic [15:0] dt);
		@(posedge clkSys);
		hostMem.we <= 1'b1;
		hostMem.sel <= s;
		hostMem.addr <= ad;
		hostMem.data <= dt;
		@(posedge clkSys);
		hostMem.we <= 1'b0;
	endtask

	// Operand digits sit least significant first, wrapping at 128 words
	task automatic load(input logic [1:0] s, p, input logic [255:0] v,
		input int d);
		for (int k = 0; k < d; k++) wr(s, 7'((p * 32 + k) % 128), v[16*k+:16]);
	endtask

	task automatic rdv(input logic [1:0] s, p, input int d,
		output logic [255:0] v);
		v = '0;
		for (int k = 0; k < d; k++) begin
			@(posedge clkSys);
			hostMem.sel <= s;
			hostMem.addr <= 7'((p * 32 + k) % 128);
			@(posedge clkSys);
			@(posedge clkSys);
			#1;
			v[16*k+:16] = memRdData;
		end
	endtask

	// Start a routine, poke a stray start while busy, wait for done
	task automatic run(input logic [3:0] ent, input logic [1:0] ap, bp, np,
		input int d, input logic ecc, bf, expErr);
		int w;
		@(posedge clkSys);
		cmd.start <= 1'b1;
		cmd.entry <= ent;
		cmd.aOperandPointer <= ap;
		cmd.bOperandPointer <= bp;
		cmd.nOperandPointer <= np;
		cmd.modSize <= 7'(d - 1);
		cmd.eccSelect <= ecc;
		cmd.binaryFieldSelect <= bf;
		@(posedge clkSys);
		cmd.start <= 1'b0;
		#1;
		check("cmdError", expErr, cmdError);
		check("busy", !expErr, busy);
		if (expErr) return;
		for (w = 0; w < 5000; w++) begin
			@(posedge clkSys);
			cmd.start <= (w == 2);
			#1;
			if (done) break;
		end
		if (w == 5000) begin
			errorCnt++;
			$display("MISMATCH done expected 1 seen 0");
			finishTest;
		end
		check("busyAtDone", 0, busy);
	endtask

	// Random operands below N; model result against B, A must survive
	task automatic scen(input logic [3:0] ent, input logic [1:0] ap, bp, np,
		input int d);
		logic [255:0] n, a, b, e, g;
		n = randVec(d);
		n[0] = 1'b1;
		n[16*d-1] = 1'b1;
		a = randVec(d) % n;
		b = randVec(d) % n;
		load(SEL_N, np, n, d);
		load(SEL_A, ap, a, d);
		load(SEL_B, bp, b, d);
		run(ent, ap, bp, np, d, 1'b0, 1'b0, 1'b0);
		if (ent == ENTRY_ADD) e = (a + b) % n;
		else if (ent == ENTRY_MUL) e = mont(a, b, n, d);
		else e = mont(mont(a, b, n, d), 256'h1, n, d);
		// Only B and A are read back; scratch words are left unchecked
		rdv(SEL_B, bp, d, g);
		check("resultB", e, g);
		rdv(SEL_A, ap, d, g);
		check("operandA", a, g);
	endtask

	// Reset, routines at several pointers and sizes of 4 to 6 digits, then refusals
	initial begin
		hostMem = '0;
		cmd = '0;
		sysRst = 1'b1;
		errorCnt = 0;
		cmpCount = 0;
		repeat (4) @(posedge clkSys);
		sysRst <= 1'b0;
		#1;
		check("resetOuts", 0, {busy, done, cmdError, memRdData});
		for (int r = 0; r < 2; r++) begin
			scen(ENTRY_MUL, 2'h1, 2'h2, 2'h3, 5);
			scen(ENTRY_MUL2, 2'h0, 2'h0, 2'h0, 5 + r);
			scen(ENTRY_ADD, 2'h2, 2'h3, 2'h0, 4 + r);
		end
		run(4'h9, 2'h0, 2'h0, 2'h0, 5, 1'b0, 1'b0, 1'b1);
		run(ENTRY_MUL, 2'h0, 2'h0, 2'h0, 5, 1'b1, 1'b0, 1'b1);
		run(ENTRY_ADD, 2'h0, 2'h0, 2'h0, 4, 1'b0, 1'b1, 1'b1);
		finishTest;
	end
endmodule
